// ===== inc/ser_pkg.sv
/*
  Constants, types and helpers of the status and event reporting block.
  Assumes a 32-bit AHB-Lite slave decoding the low 8 address bits.
*/
package ser_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_EVT    = 8'h04;
  localparam logic [7:0] OFS_DEV_EN = 8'h08;
  localparam logic [7:0] OFS_EVT_EN = 8'h0C;
  localparam logic [7:0] OFS_SRQ_EN = 8'h10;
  localparam logic [7:0] OFS_STB    = 8'h18;
  localparam logic [7:0] OFS_RESP   = 8'h1C;
  localparam logic [7:0] DEV_EN_RST = 8'hFF;
  localparam logic [7:0] EVT_EN_RST = 8'h00;
  localparam logic [7:0] SRQ_EN_RST = 8'h00;
  // ==========================================
  // Command codes in the command register
  localparam logic [3:0] CMD_ESR_Q   = 4'h1;
  localparam logic [3:0] CMD_ALL_Q   = 4'h2;
  localparam logic [3:0] CMD_EVENT_Q = 4'h3;
  localparam logic [3:0] CMD_MSG_Q   = 4'h4;
  localparam logic [3:0] CMD_OPC     = 4'h5;
  localparam logic [3:0] CMD_OPC_Q   = 4'h6;
  localparam logic [3:0] CMD_WAI     = 4'h7;
  localparam logic [3:0] CMD_CAL_Q   = 4'h8;
  localparam logic [3:0] CMD_RST     = 4'h9;
  localparam logic [3:0] CMD_TST_Q   = 4'hA;
  localparam logic [3:0] CMD_SELF_CAL = 4'hB;
  // ==========================================
  // Event codes
  localparam logic [9:0] EV_EMPTY = 10'h000;
  localparam logic [9:0] EV_PEND  = 10'h001;
  localparam logic [9:0] EV_CMD   = 10'h064;
  localparam logic [9:0] EV_SYN   = 10'h066;
  localparam logic [9:0] EV_TYPE  = 10'h068;
  localparam logic [9:0] EV_PARM  = 10'h06C;
  localparam logic [9:0] EV_EXE   = 10'h0C8;
  localparam logic [9:0] EV_RANGE = 10'h0DE;
  localparam logic [9:0] EV_DEV   = 10'h12C;
  localparam logic [9:0] EV_TST   = 10'h14A;
  localparam logic [9:0] EV_OVFL  = 10'h15E;
  localparam logic [9:0] EV_PON   = 10'h191;
  localparam logic [9:0] EV_OPC   = 10'h192;
  localparam logic [9:0] EV_QINT  = 10'h19A;
  localparam logic [9:0] EV_QUNT  = 10'h1A4;
  localparam logic [9:0] EV_QIND  = 10'h1B8;
  // ==========================================
  // Bit positions
  localparam int ESR_PON = 7;
  localparam int ESR_CME = 5;
  localparam int ESR_EXE = 4;
  localparam int ESR_DDE = 3;
  localparam int ESR_QYE = 2;
  localparam int ESR_OPC = 0;
  localparam int STB_RQS = 6;
  localparam int STB_ESB = 5;
  localparam int STB_MAV = 4;
  // ==========================================
  // Queues; response word is {kind, value}
  localparam logic [3:0] EVQ_DEPTH = 4'hA;
  localparam int         EVQ_AW    = 4;
  localparam int         RSQ_AW    = 4;
  localparam logic [4:0] RSQ_DEPTH = 5'h10;
  localparam logic [1:0] RK_NUM    = 2'h0;
  localparam logic [1:0] RK_MSG    = 2'h1;
  localparam logic [1:0] RK_CHR    = 2'h2;
  localparam logic [7:0] CHR_ONE   = 8'h31;
  typedef struct packed {
    logic [1:0] kind;
    logic [9:0] val;
  } ser_resp_t;
  // ==========================================
  // Bus carriers
  typedef struct packed {
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } ser_ahb_req_t;
  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } ser_ahb_rsp_t;

  // Event status bit raised by a code
  function automatic logic [7:0] ser_event_bit(input logic [9:0] code);
    logic [7:0] b;
    b = 8'h00;
    case (code)
      EV_CMD, EV_SYN, EV_TYPE, EV_PARM: b[ESR_CME] = 1'b1;
      EV_EXE, EV_RANGE:                 b[ESR_EXE] = 1'b1;
      EV_DEV, EV_TST:                   b[ESR_DDE] = 1'b1;
      EV_PON:                           b[ESR_PON] = 1'b1;
      EV_OPC:                           b[ESR_OPC] = 1'b1;
      EV_QINT, EV_QUNT, EV_QIND:        b[ESR_QYE] = 1'b1;
      default:                          b = 8'h00;
    endcase
    return b;
  endfunction : ser_event_bit
endpackage : ser_pkg

// ===== tb/ser_op_model.sv
/*
  Long-operation engine model: stays busy LAT cycles after each start.
  Assumes start pulses come from the status block on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_op_model #(
  parameter int LAT = 20
) (
  input  wire logic mclk,     // Clock
  input  wire logic reset_n,  // Async reset
  input  wire logic op_start, // Start pulse
  output logic      op_busy   // Pending level
);
  int cnt;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cnt <= 0;
    else if (op_start)
      cnt <= LAT;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign op_busy = (cnt != 0);
endmodule : ser_op_model
`default_nettype wire

// ===== tb/ser_status_tb.sv
/*
  Self-checking bench: AHB-Lite master tasks and status/event tests.
  Assumes ser_op_model as the long-operation engine.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_status_tb;
  logic                  mclk = 1'b0;
  logic                  reset_n = 1'b0;
  logic [7:0]            haddr = 8'h00;
  logic [1:0]            htrans = 2'h0;
  logic                  hwrite = 1'b0;
  logic [31:0]           hwdata = 32'h00000000;
  logic                  op_busy;
  logic                  op_start;
  logic                  srq_n;
  logic [3:0]            op_kind;
  logic [31:0]           v;
  int                    error_cnt = 0;
  int                    cmp_count = 0;
  int                    st_cnt = 0;
  int                    n;
  ser_pkg::ser_ahb_req_t req;
  ser_pkg::ser_ahb_rsp_t rsp;
  assign req = '{hsel: 1'b1, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2,
                 hready: rsp.hreadyout, hwdata: hwdata};
  ser_status dut_u (.mclk(mclk), .reset_n(reset_n), .ahb_req(req), .ahb_rsp(rsp),
    .op_busy(op_busy), .op_start(op_start), .op_kind(op_kind), .srq_n(srq_n));
  ser_op_model #(.LAT(20)) op_u (.mclk(mclk), .reset_n(reset_n), .op_start(op_start),
    .op_busy(op_busy));
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  // Counts long-operation start pulses
  always @(posedge mclk)
  begin
    if (op_start)
    begin
      st_cnt <= st_cnt + 1;
    end
  end
  // ==========
  // Bus tasks
  task automatic wait_rdy();
    logic ok;
    do
    begin
      @(negedge mclk);
      ok = rsp.hreadyout;
      v = rsp.hrdata;
      @(posedge mclk);
    end
    while (ok !== 1'b1);
  endtask : wait_rdy
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h00000000);
    chk(v, e);
  endtask : rdc
  task automatic cmd(input logic [3:0] c);
    bus(ser_pkg::OFS_CMD, 1'b1, {28'h0000000, c});
  endtask : cmd
  task automatic ev(input logic [9:0] c);
    bus(ser_pkg::OFS_EVT, 1'b1, {22'h000000, c});
  endtask : ev
  task automatic resp(input logic [1:0] k, input logic [9:0] x);
    rdc(ser_pkg::OFS_RESP, {20'h00000, k, x});
  endtask : resp
  task automatic fin(input string s);
    $display("end of test %s", s);
  endtask : fin
  task automatic print_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end
  // ==========
  // Tests
  initial
  begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc(ser_pkg::OFS_STB, 32'h00000000);
    chk({31'h0, srq_n}, 32'h1);
    fin("reset");
    bus(ser_pkg::OFS_EVT_EN, 1'b1, 32'h00000020);
    bus(ser_pkg::OFS_SRQ_EN, 1'b1, 32'h00000020);
    ev(ser_pkg::EV_CMD);
    rdc(ser_pkg::OFS_STB, 32'h00000060);
    chk({31'h0, srq_n}, 32'h0);
    cmd(ser_pkg::CMD_EVENT_Q);
    resp(ser_pkg::RK_NUM, ser_pkg::EV_PEND);
    cmd(ser_pkg::CMD_ESR_Q);
    rdc(ser_pkg::OFS_STB, 32'h00000010);
    chk({31'h0, srq_n}, 32'h1);
    resp(ser_pkg::RK_NUM, 10'h0A0);
    cmd(ser_pkg::CMD_ALL_Q);
    resp(ser_pkg::RK_MSG, ser_pkg::EV_PON);
    resp(ser_pkg::RK_MSG, ser_pkg::EV_CMD);
    rdc(ser_pkg::OFS_STB, 32'h00000000);
    fin("summary");
    bus(ser_pkg::OFS_DEV_EN, 1'b1, 32'h000000EF);
    rdc(ser_pkg::OFS_DEV_EN, 32'h000000EF);
    ev(ser_pkg::EV_RANGE);
    cmd(ser_pkg::CMD_ESR_Q);
    resp(ser_pkg::RK_NUM, 10'h000);
    cmd(ser_pkg::CMD_MSG_Q);
    resp(ser_pkg::RK_MSG, ser_pkg::EV_EMPTY);
    bus(ser_pkg::OFS_DEV_EN, 1'b1, 32'h000000FF);
    repeat (11) ev(ser_pkg::EV_EXE);
    cmd(ser_pkg::CMD_ESR_Q);
    resp(ser_pkg::RK_NUM, 10'h010);
    cmd(ser_pkg::CMD_ALL_Q);
    for (n = 0; n < 10; n++)
      resp(ser_pkg::RK_MSG, (n == 9) ? ser_pkg::EV_OVFL : ser_pkg::EV_EXE);
    fin("queue");
    ev(ser_pkg::EV_DEV);
    cmd(ser_pkg::CMD_ESR_Q);
    resp(ser_pkg::RK_NUM, 10'h008);
    ev(ser_pkg::EV_TST);
    cmd(ser_pkg::CMD_ESR_Q);
    resp(ser_pkg::RK_NUM, 10'h008);
    cmd(ser_pkg::CMD_EVENT_Q);
    resp(ser_pkg::RK_NUM, ser_pkg::EV_TST);
    fin("requery");
    cmd(ser_pkg::CMD_SELF_CAL);
    cmd(ser_pkg::CMD_OPC_Q);
    rdc(ser_pkg::OFS_STB, 32'h00000000);
    n = 0;
    do
    begin
      bus(ser_pkg::OFS_STB, 1'b0, 32'h00000000);
      n++;
    end
    while (v[4] !== 1'b1 && n < 200);
    chk({31'h0, op_busy}, 32'h0);
    chk({28'h0, op_kind}, {28'h0, ser_pkg::CMD_SELF_CAL});
    resp(ser_pkg::RK_CHR, {2'h0, ser_pkg::CHR_ONE});
    cmd(ser_pkg::CMD_RST);
    cmd(ser_pkg::CMD_OPC);
    cmd(ser_pkg::CMD_WAI);
    cmd(4'hF);
    chk({31'h0, op_busy}, 32'h0);
    repeat (2) @(posedge mclk);
    cmd(ser_pkg::CMD_ESR_Q);
    resp(ser_pkg::RK_NUM, 10'h001);
    fin("sync");
    cmd(ser_pkg::CMD_ESR_Q);
    cmd(4'hF);
    rdc(ser_pkg::OFS_STB, 32'h00000000);
    cmd(ser_pkg::CMD_ESR_Q);
    resp(ser_pkg::RK_NUM, 10'h004);
    fin("flush");
    ev(ser_pkg::EV_SYN);
    ev(ser_pkg::EV_TYPE);
    ev(ser_pkg::EV_PARM);
    ev(ser_pkg::EV_QUNT);
    ev(ser_pkg::EV_QIND);
    ev(ser_pkg::EV_RANGE);
    chk({31'h0, srq_n}, 32'h0);
    cmd(ser_pkg::CMD_ESR_Q);
    resp(ser_pkg::RK_NUM, 10'h034);
    cmd(ser_pkg::CMD_ALL_Q);
    resp(ser_pkg::RK_MSG, ser_pkg::EV_SYN);
    resp(ser_pkg::RK_MSG, ser_pkg::EV_TYPE);
    resp(ser_pkg::RK_MSG, ser_pkg::EV_PARM);
    resp(ser_pkg::RK_MSG, ser_pkg::EV_QUNT);
    resp(ser_pkg::RK_MSG, ser_pkg::EV_QIND);
    resp(ser_pkg::RK_MSG, ser_pkg::EV_RANGE);
    fin("codes");
    cmd(ser_pkg::CMD_CAL_Q);
    @(posedge mclk);
    chk({28'h0, op_kind}, {28'h0, ser_pkg::CMD_CAL_Q});
    cmd(ser_pkg::CMD_TST_Q);
    repeat (2) @(posedge mclk);
    chk({28'h0, op_kind}, {28'h0, ser_pkg::CMD_TST_Q});
    chk(st_cnt, 32'h00000004);
    fin("long");
    print_verdict();
  end
endmodule : ser_status_tb
`default_nettype wire

// ===== verilog/ser_ram.sv
/*
  Small synchronous memory with registered read data.
  Assumes read address is the next-cycle address; writes bypass to it.
*/
`timescale 1ns/1ps
`default_nettype none
module ser_ram #(
  parameter int W  = 8,
  parameter int D  = 16,
  parameter int AW = 4
) (
  input  wire logic          mclk,   // Clock
  input  wire logic          we,     // Write strobe
  input  wire logic [AW-1:0] waddr,  // Write address
  input  wire logic [W-1:0]  wdata,  // Write data
  input  wire logic [AW-1:0] raddr,  // Read address
  output logic      [W-1:0]  rdata   // Registered read data
);
  logic [W-1:0] mem [D];

  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    // Bypass keeps a just-written head visible
    if (we && (waddr == raddr))
    begin
      rdata <= wdata;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end
endmodule : ser_ram
`default_nettype wire

// ===== verilog/ser_status.sv
/*
  Status byte, event status, event queue and response queue over AHB-Lite.
  Assumes a single AHB-Lite master, word transfers, and an op_busy level
  from the long-running operations.
*/
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ser_status (
  input  wire logic                 mclk,     // 125 MHz clock
  input  wire logic                 reset_n,  // Async reset
  input  wire ser_pkg::ser_ahb_req_t ahb_req, // AHB-Lite request
  output ser_pkg::ser_ahb_rsp_t     ahb_rsp,  // AHB-Lite response
  input  wire logic                 op_busy,  // Long operation pending
  output logic                      op_start, // Long operation start
  output logic [3:0]                op_kind,  // Command that started it
  output logic                      srq_n     // Service request line
);
  // ==========================================
  // State
  typedef enum logic [0:0] {S_IDLE, S_EMIT} ser_fsm_t;
  typedef struct packed {
    logic [7:0]  dev_en;
    logic [7:0]  evt_en;
    logic [7:0]  srq_en;
    logic [7:0]  esr;
    logic        event_summary_bit;
    logic [3:0]  ev_head;
    logic [3:0]  ev_cnt;
    logic [3:0]  ev_rcnt;
    logic [3:0]  rs_head;
    logic [4:0]  rs_cnt;
    ser_fsm_t    fsm;
    logic        q_msg;
    logic        q_all;
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic        rd_done;
    logic [31:0] hrdata;
    logic        wai_hold;
    logic        opc_arm;
    logic        opcq_arm;
    logic        pon_pend;
    logic        qint_pend;
    logic        op_start;
    logic [3:0]  op_kind;
  } ser_state_t;

  ser_state_t        s;
  ser_state_t        next_s;
  logic [9:0]        ev_rdata;
  ser_pkg::ser_resp_t rs_rdata;
  logic              ev_we;
  logic [3:0]        ev_waddr;
  logic [9:0]        ev_wdata;
  logic              rs_we;
  logic [3:0]        rs_waddr;
  ser_pkg::ser_resp_t rs_wdata;
  logic [7:0]        status_byte;
  logic              master_summary_bit;
  logic              stall;
  logic              dp_done;
  logic              cmd_exec;
  logic              evt_exec;
  logic              ev_take;
  logic [9:0]        ev_code;
  logic [7:0]        ev_bit;
  logic [3:0]        cmd;

  // Index plus offset, wrapped at event queue depth
  function automatic logic [3:0] ev_wrap(input logic [3:0] a, input logic [3:0] b);
    logic [4:0] t;
    t = {1'b0, a} + {1'b0, b};
    if (t >= {1'b0, ser_pkg::EVQ_DEPTH})
    begin
      t = t - {1'b0, ser_pkg::EVQ_DEPTH};
    end
    return t[3:0];
  endfunction : ev_wrap

  // ==========================================
  // Status byte and service request
  always_comb
  begin
    status_byte                   = 8'h00;
    status_byte[ser_pkg::STB_ESB] = s.event_summary_bit;
    status_byte[ser_pkg::STB_MAV] = (s.rs_cnt != 5'h00);
    master_summary_bit                           = |(status_byte & s.srq_en & 8'hBF);
    status_byte[ser_pkg::STB_RQS] = master_summary_bit;
  end

  // line released once no enabled bit
  assign srq_n    = ~master_summary_bit;
  assign op_start = s.op_start;
  assign op_kind  = s.op_kind;

  // ==========================================
  // Bus data phase
  assign cmd = ahb_req.hwdata[3:0];
  always_comb
  begin
    stall = 1'b0;
    if (s.dp_valid && s.dp_write && (s.fsm != S_IDLE) &&
        (s.dp_addr == ser_pkg::OFS_CMD || s.dp_addr == ser_pkg::OFS_EVT))
    begin
      stall = 1'b1;
    end
    if (s.dp_valid && s.dp_write && s.wai_hold && op_busy &&
        s.dp_addr == ser_pkg::OFS_CMD)
    begin
      stall = 1'b1;
    end
    if (s.dp_valid && !s.dp_write && !s.rd_done)
    begin
      stall = 1'b1;
    end
  end

  assign dp_done  = s.dp_valid && !stall;
  assign cmd_exec = dp_done && s.dp_write && s.dp_addr == ser_pkg::OFS_CMD;
  assign evt_exec = dp_done && s.dp_write && s.dp_addr == ser_pkg::OFS_EVT;

  always_comb
  begin
    ahb_rsp.hreadyout = ~stall;
    ahb_rsp.hresp     = 1'b0;
    ahb_rsp.hrdata    = s.hrdata;
  end

  // ==========================================
  // Event source selection
  always_comb
  begin
    ev_take = 1'b0;
    ev_code = ser_pkg::EV_EMPTY;
    if (evt_exec)
    begin
      ev_take = 1'b1;
      ev_code = ahb_req.hwdata[9:0];
    end
    else if (s.fsm == S_IDLE && !cmd_exec)
    begin
      if (s.pon_pend)
      begin
        ev_take = 1'b1;
        ev_code = ser_pkg::EV_PON;
      end
      else if (s.opc_arm && !op_busy)
      begin
        ev_take = 1'b1;
        ev_code = ser_pkg::EV_OPC;
      end
      else if (s.qint_pend)
      begin
        ev_take = 1'b1;
        ev_code = ser_pkg::EV_QINT;
      end
    end
    ev_bit = ser_pkg::ser_event_bit(ev_code);
  end

  // ==========================================
  // Next state
  always_comb
  begin
    next_s     = s;
    ev_we      = 1'b0;
    ev_waddr   = ev_wrap(s.ev_head, s.ev_cnt);
    ev_wdata   = ev_code;
    rs_we      = 1'b0;
    rs_waddr   = s.rs_head + s.rs_cnt[3:0];
    rs_wdata   = '0;
    next_s.op_start = 1'b0;

    if (ahb_req.hready)
    begin
      next_s.dp_valid = ahb_req.hsel && ahb_req.htrans[1];
      next_s.dp_write = ahb_req.hwrite;
      next_s.dp_addr  = ahb_req.haddr;
      next_s.rd_done  = 1'b0;
    end

    // Register reads take one wait state in S_IDLE; in S_EMIT they wait until S_IDLE
    if (s.dp_valid && !s.dp_write && !s.rd_done && s.fsm == S_IDLE)
    begin
      next_s.rd_done = 1'b1;
      case (s.dp_addr)
        ser_pkg::OFS_DEV_EN: next_s.hrdata = {24'h000000, s.dev_en};
        ser_pkg::OFS_EVT_EN: next_s.hrdata = {24'h000000, s.evt_en};
        ser_pkg::OFS_SRQ_EN: next_s.hrdata = {24'h000000, s.srq_en};
        ser_pkg::OFS_STB:    next_s.hrdata = {24'h000000, status_byte};
        ser_pkg::OFS_RESP:
        begin
          next_s.hrdata = 32'h00000000;
          if (s.rs_cnt != 5'h00)
          begin
            next_s.hrdata  = {20'h00000, rs_rdata};
            next_s.rs_head = s.rs_head + 4'h1;
            next_s.rs_cnt  = s.rs_cnt - 5'h01;
          end
        end
        default:             next_s.hrdata = 32'h00000000;
      endcase
    end
    else if (s.dp_valid && !s.dp_write && s.fsm != S_IDLE)
    begin
      next_s.rd_done = 1'b0;
    end

    if (dp_done && s.dp_write)
    begin
      case (s.dp_addr)
        ser_pkg::OFS_DEV_EN: next_s.dev_en = ahb_req.hwdata[7:0];
        ser_pkg::OFS_EVT_EN: next_s.evt_en = ahb_req.hwdata[7:0];
        ser_pkg::OFS_SRQ_EN: next_s.srq_en = ahb_req.hwdata[7:0];
        default:             next_s.dev_en = s.dev_en;
      endcase
    end

    if (!op_busy)
    begin
      next_s.wai_hold = 1'b0;
    end

    // ------------------------------------------
    if (cmd_exec)
    begin
      next_s.rs_head = s.rs_head + s.rs_cnt[3:0];
      next_s.rs_cnt  = 5'h00;
      if (s.rs_cnt != 5'h00)
      begin
        next_s.qint_pend = 1'b1;
      end
      rs_waddr = s.rs_head + s.rs_cnt[3:0];
      case (cmd)
        ser_pkg::CMD_ESR_Q:
        begin
          rs_we           = 1'b1;
          rs_wdata        = {ser_pkg::RK_NUM, 2'b00, s.esr};
          next_s.rs_cnt   = 5'h01;
          next_s.esr      = 8'h00;
          next_s.event_summary_bit      = 1'b0;
          next_s.ev_head  = ev_wrap(s.ev_head, s.ev_rcnt);
          next_s.ev_cnt   = s.ev_cnt - s.ev_rcnt;
          next_s.ev_rcnt  = s.ev_cnt - s.ev_rcnt;
        end
        ser_pkg::CMD_ALL_Q, ser_pkg::CMD_EVENT_Q, ser_pkg::CMD_MSG_Q:
        begin
          next_s.q_all = (cmd == ser_pkg::CMD_ALL_Q);
          next_s.q_msg = (cmd != ser_pkg::CMD_EVENT_Q);
          if (s.ev_rcnt != 4'h0)
          begin
            next_s.fsm = S_EMIT;
          end
          else
          begin
            rs_we         = 1'b1;
            rs_wdata.kind = (cmd == ser_pkg::CMD_EVENT_Q) ? ser_pkg::RK_NUM : ser_pkg::RK_MSG;
            rs_wdata.val  = (s.ev_cnt == 4'h0) ? ser_pkg::EV_EMPTY : ser_pkg::EV_PEND;
            next_s.rs_cnt = 5'h01;
          end
        end
        ser_pkg::CMD_OPC:   next_s.opc_arm  = 1'b1;
        ser_pkg::CMD_OPC_Q: next_s.opcq_arm = 1'b1;
        ser_pkg::CMD_WAI:   next_s.wai_hold = op_busy;
        ser_pkg::CMD_CAL_Q, ser_pkg::CMD_RST, ser_pkg::CMD_TST_Q, ser_pkg::CMD_SELF_CAL:
        begin
          next_s.op_start = 1'b1;
          next_s.op_kind  = cmd;
        end
        default:            next_s.op_kind  = s.op_kind;
      endcase
    end
    else if (s.opcq_arm && !op_busy && s.fsm == S_IDLE && !s.dp_valid &&
             s.rs_cnt != ser_pkg::RSQ_DEPTH)
    begin
      rs_we           = 1'b1;
      rs_wdata        = {ser_pkg::RK_CHR, 2'b00, ser_pkg::CHR_ONE};
      next_s.rs_cnt   = s.rs_cnt + 5'h01;
      next_s.opcq_arm = 1'b0;
    end

    // ------------------------------------------
    if (s.fsm == S_EMIT)
    begin
      rs_we          = s.rs_cnt != ser_pkg::RSQ_DEPTH;
      rs_wdata.kind  = s.q_msg ? ser_pkg::RK_MSG : ser_pkg::RK_NUM;
      rs_wdata.val   = ev_rdata;
      next_s.rs_cnt  = s.rs_cnt + {4'h0, rs_we};
      next_s.ev_head = ev_wrap(s.ev_head, 4'h1);
      next_s.ev_cnt  = s.ev_cnt - 4'h1;
      next_s.ev_rcnt = s.ev_rcnt - 4'h1;
      if (!s.q_all || s.ev_rcnt == 4'h1)
      begin
        next_s.fsm = S_IDLE;
      end
    end

    // ------------------------------------------
    if (ev_take)
    begin
      if (ev_code == ser_pkg::EV_PON)
      begin
        next_s.pon_pend = 1'b0;
      end
      else if (ev_code == ser_pkg::EV_OPC && !evt_exec)
      begin
        next_s.opc_arm = 1'b0;
      end
      else if (ev_code == ser_pkg::EV_QINT && !evt_exec)
      begin
        next_s.qint_pend = 1'b0;
      end
      if ((ev_bit & s.dev_en) != 8'h00)
      begin
        next_s.esr = s.esr | ev_bit;
        if ((ev_bit & s.evt_en) != 8'h00)
        begin
          next_s.event_summary_bit = 1'b1;
        end
        ev_we = 1'b1;
        if (s.ev_cnt != ser_pkg::EVQ_DEPTH)
        begin
          next_s.ev_cnt = s.ev_cnt + 4'h1;
        end
        else
        begin
          ev_waddr = ev_wrap(s.ev_head, ser_pkg::EVQ_DEPTH - 4'h1);
          ev_wdata = ser_pkg::EV_OVFL;
        end
      end
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s           <= '0;
      s.fsm       <= S_IDLE;
      s.dev_en    <= ser_pkg::DEV_EN_RST;
      s.evt_en    <= ser_pkg::EVT_EN_RST;
      s.srq_en    <= ser_pkg::SRQ_EN_RST;
      s.pon_pend  <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================
  // Queue memories
  ser_ram #(.W(10), .D(10), .AW(ser_pkg::EVQ_AW)) u_evq (
    .mclk  (mclk),
    .we    (ev_we),
    .waddr (ev_waddr),
    .wdata (ev_wdata),
    .raddr (next_s.ev_head),
    .rdata (ev_rdata)
  );

  ser_ram #(.W(12), .D(16), .AW(ser_pkg::RSQ_AW)) u_rsq (
    .mclk  (mclk),
    .we    (rs_we),
    .waddr (rs_waddr),
    .wdata (rs_wdata),
    .raddr (next_s.rs_head),
    .rdata (rs_rdata)
  );

  // ==========================================
  // Checks
  property p_mav;
    @(posedge mclk) disable iff (!reset_n) (s.rs_cnt != 5'h00) |-> status_byte[4];
  endproperty
  a_mav: assert property (p_mav) else $error("message bit low with responses");
  property p_flush;
    @(posedge mclk) disable iff (!reset_n)
      cmd_exec && s.rs_cnt != 5'h00 |=> s.qint_pend && s.rs_cnt <= 5'h01;
  endproperty
  a_flush: assert property (p_flush) else $error("lost responses not flagged");
  property p_depth;
    @(posedge mclk) disable iff (!reset_n) s.ev_cnt <= 4'hA && s.ev_rcnt <= s.ev_cnt;
  endproperty
  a_depth: assert property (p_depth) else $error("event queue count wrong");
  property p_ovfl;
    @(posedge mclk) disable iff (!reset_n)
      ev_take && (ev_bit & s.dev_en) != 8'h00 && s.ev_cnt == 4'hA |->
      ev_wdata == 10'h15E ##1 s.ev_cnt == 4'hA;
  endproperty
  a_ovfl: assert property (p_ovfl) else $error("overflow not coded");
  property p_esr_clr;
    @(posedge mclk) disable iff (!reset_n)
      cmd_exec && cmd == 4'h1 |=> s.esr == 8'h00 && !s.event_summary_bit && s.ev_rcnt == s.ev_cnt;
  endproperty
  a_esr_clr: assert property (p_esr_clr) else $error("status query did not clear");
  property p_gate;
    @(posedge mclk) disable iff (!reset_n)
      ev_take && (ev_bit & s.dev_en) == 8'h00 |=> $stable(s.ev_cnt) && $stable(s.esr);
  endproperty
  a_gate: assert property (p_gate) else $error("masked event recorded");
  property p_srq;
    @(posedge mclk) disable iff (!reset_n)
      (s.event_summary_bit && s.srq_en[ser_pkg::STB_ESB]) ||
      (s.rs_cnt != 5'h00 && s.srq_en[ser_pkg::STB_MAV])
      |-> !srq_n && status_byte[ser_pkg::STB_RQS];
  endproperty
  a_srq: assert property (p_srq) else $error("service request missing");
  property p_srq_off;
    @(posedge mclk) disable iff (!reset_n)
      !((s.event_summary_bit && s.srq_en[ser_pkg::STB_ESB]) ||
        (s.rs_cnt != 5'h00 && s.srq_en[ser_pkg::STB_MAV]))
      |-> srq_n && !status_byte[ser_pkg::STB_RQS];
  endproperty
  a_srq_off: assert property (p_srq_off) else $error("service request kept");
  property p_wai;
    @(posedge mclk) disable iff (!reset_n)
      s.wai_hold && op_busy && s.dp_valid && s.dp_write && s.dp_addr == 8'h00
      |-> !ahb_rsp.hreadyout;
  endproperty
  a_wai: assert property (p_wai) else $error("command ran during wait");
  property p_opcq;
    @(posedge mclk) disable iff (!reset_n) s.opcq_arm && op_busy |=> s.opcq_arm;
  endproperty
  a_opcq: assert property (p_opcq) else $error("completion answered early");
  c_ovfl: cover property (@(posedge mclk) ev_take && s.ev_cnt == 4'hA);
  c_all:  cover property (@(posedge mclk) s.fsm == S_EMIT && s.q_all && s.ev_rcnt == 4'h3);
  c_srq:  cover property (@(posedge mclk) !srq_n);
  c_wai:  cover property (@(posedge mclk) s.wai_hold && stall);
endmodule : ser_status
`default_nettype wire
